// ===== src/sys_flag_map.svh
`ifndef SYS_FLAG_MAP_SVH
`define SYS_FLAG_MAP_SVH

// register byte offsets
`define FLAG_STATUS_OFFSET 12'h000
`define INT_STATUS_OFFSET 12'h004
`define INT_MASK_OFFSET 12'h008
`define BUF_SIZE_OFFSET 12'h00C
`define MOTOR_CMD_OFFSET 12'h010
`define CHECK_CTRL_OFFSET 12'h014

// field positions, shared by flag, event status and mask registers
`define BUF_OVF_BIT 0
`define ABORT_BIT 1
`define NO_CLK_BIT 2
`define MOTOR_REFUSED_BIT 3
`define INT_WIDTH 4

// reset values and ram capacity
`define INT_MASK_RESET 4'h0
`define BUF_SIZE_RESET 16'h0100
`define RAM_CAPACITY 16'h1000

// clock detection window
`define CLK_WINDOW_NS 10000
`define CLK_PERIOD_NS 10
`define CLK_WINDOW_CYCLES (`CLK_WINDOW_NS / `CLK_PERIOD_NS)

`endif

// ===== src/sys_flag_pkg.sv
package sys_flag_pkg;
    typedef enum logic [1:0] {
        check_idle,
        check_run,
        check_done
    } check_state_type;
endpackage

// ===== src/system_error_flag_bank.sv
// What this block does
// - every flag is one bit; zero means no error, one means present
// - buffer overflow flag sets when configured buffer exceeds ram capacity
// - buffer overflow check runs only at power-up or controller reset
// - on overflow the default buffer size replaces the configured one
// - abort flag sets on abort input and stays set afterwards
// - abort is detected any time the abort input stays asserted for two clock cycles
// - at power-up or reset, missing phase or servo clock sets flag
// - while missing clock flag is set, motor enable requests are refused
// - flags clear only by power cycle or reset command
`timescale 1ns/1ps
`include "sys_flag_map.svh"

module system_error_flag_bank #(
    parameter int CLK_WINDOW = `CLK_WINDOW_CYCLES,
    parameter int AXES = 8
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // reset command string received
    input wire logic reset_cmd_in,
    // external pins
    input wire logic abort_in,
    input wire logic phase_clk_in,
    input wire logic servo_clk_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // motion side
    output logic [AXES-1:0] motor_enable_out,
    output logic [15:0] buffer_size_out,
    output logic irq_out
);

    // window counter and read mux only serve these ranges
    if (CLK_WINDOW < 2 || AXES < 1 || AXES > 16) begin : g_bad_params
        $error("system_error_flag_bank: unsupported parameters");
    end

    // three-stage synchronisers; compare stages 2 and 3 only
    logic [2:0] abort_sync;
    logic [2:0] phase_sync;
    logic [2:0] servo_sync;
    logic abort_level;
    logic phase_edge;
    logic servo_edge;
    logic phase_agree;
    logic servo_agree;
    logic phase_level;
    logic servo_level;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            abort_sync <= 3'h0;
        end else begin
            abort_sync <= {abort_sync[1:0], abort_in};
        end
    end

    // no reset here: a forced low would fake a rise on a stuck-high clock
    always_ff @(posedge clock_in) begin
        phase_sync <= {phase_sync[1:0], phase_clk_in};
        servo_sync <= {servo_sync[1:0], servo_clk_in};
    end

    // abort counts once stages 2 and 3 agree high
    assign abort_level = abort_sync[1] & abort_sync[2];
    assign phase_agree = phase_sync[1] == phase_sync[2];
    assign servo_agree = servo_sync[1] == servo_sync[2];

    // agreed clock levels; reset high so a rise needs a low seen first
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            phase_level <= 1'b1;
            servo_level <= 1'b1;
        end else begin
            if (phase_agree) begin
                phase_level <= phase_sync[2];
            end
            if (servo_agree) begin
                servo_level <= servo_sync[2];
            end
        end
    end

    // a rise counts once, when the agreed level goes from low to high
    assign phase_edge = phase_agree & phase_sync[2] & ~phase_level;
    assign servo_edge = servo_agree & servo_sync[2] & ~servo_level;

    // any reset source restarts the startup checks
    // command reset leaves mask, events and configured size alone
    logic restart;
    assign restart = rst_in | reset_cmd_in;

    // startup check sequencer
    sys_flag_pkg::check_state_type state;
    logic [31:0] window_count;
    logic phase_seen;
    logic servo_seen;

    always_ff @(posedge clock_in) begin
        if (restart) begin
            state <= sys_flag_pkg::check_idle;
        end else begin
            case (state)
                sys_flag_pkg::check_idle: begin
                    state <= sys_flag_pkg::check_run;
                end
                sys_flag_pkg::check_run: begin
                    if (window_count == 32'(CLK_WINDOW - 1)) begin
                        state <= sys_flag_pkg::check_done;
                    end
                end
                sys_flag_pkg::check_done: begin
                    state <= sys_flag_pkg::check_done;
                end
                default: begin
                    state <= sys_flag_pkg::check_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (restart || state != sys_flag_pkg::check_run) begin
            window_count <= 32'h0000_0000;
        end else begin
            window_count <= window_count + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (restart || state == sys_flag_pkg::check_idle) begin
            phase_seen <= 1'b0;
            servo_seen <= 1'b0;
        end else if (state == sys_flag_pkg::check_run) begin
            phase_seen <= phase_seen | phase_edge;
            servo_seen <= servo_seen | servo_edge;
        end
    end

    // configured buffer size, sampled by the check at startup only
    logic [15:0] buf_size_cfg;
    logic buffer_overflow_flag;
    logic global_abort_flag;
    logic missing_clock_flag;
    logic check_end;

    assign check_end = (state == sys_flag_pkg::check_run)
        && (window_count == 32'(CLK_WINDOW - 1));

    // apb decode; zero wait states
    logic wr_en;
    logic addr_ok;
    assign pready_out = 1'b1;
    assign wr_en = psel_in & penable_in & pwrite_in;
    always_comb begin
        case (paddr_in)
            `FLAG_STATUS_OFFSET,
            `INT_STATUS_OFFSET,
            `INT_MASK_OFFSET,
            `BUF_SIZE_OFFSET,
            `MOTOR_CMD_OFFSET,
            `CHECK_CTRL_OFFSET: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr_out = psel_in & penable_in & ~addr_ok;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            buf_size_cfg <= `BUF_SIZE_RESET;
        end else if (wr_en && paddr_in == `BUF_SIZE_OFFSET) begin
            if (pstrb_in[0]) begin
                buf_size_cfg[7:0] <= pwdata_in[7:0];
            end
            if (pstrb_in[1]) begin
                buf_size_cfg[15:8] <= pwdata_in[15:8];
            end
        end
    end

    // overflow decided once per startup check
    always_ff @(posedge clock_in) begin
        if (restart) begin
            buffer_overflow_flag <= 1'b0;
        end else if (state == sys_flag_pkg::check_idle) begin
            buffer_overflow_flag <=
                (buf_size_cfg > `RAM_CAPACITY);
        end
    end

    // the active size is latched at startup so later writes wait for reset
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            buffer_size_out <= `BUF_SIZE_RESET;
        end else if (state == sys_flag_pkg::check_idle) begin
            if (buf_size_cfg > `RAM_CAPACITY) begin
                buffer_size_out <= `BUF_SIZE_RESET;
            end else begin
                buffer_size_out <= buf_size_cfg;
            end
        end
    end

    // sticky abort; only reset sources clear it
    always_ff @(posedge clock_in) begin
        if (restart) begin
            global_abort_flag <= 1'b0;
        end else if (abort_level) begin
            global_abort_flag <= 1'b1;
        end
    end

    // clear through the window; motor writes wait on checks_done instead
    // a clock lost after the check stays unseen until the next restart
    always_ff @(posedge clock_in) begin
        if (restart) begin
            missing_clock_flag <= 1'b0;
        end else if (check_end) begin
            missing_clock_flag <= ~(phase_seen | phase_edge)
                | ~(servo_seen | servo_edge);
        end
    end

    logic checks_done;
    assign checks_done = (state == sys_flag_pkg::check_done);

    // motor enable requests
    // a refused write leaves no trace but the event bit
    logic motor_refused;
    logic motor_req;
    assign motor_req = wr_en && paddr_in == `MOTOR_CMD_OFFSET && pstrb_in[0];
    assign motor_refused = motor_req
        && (missing_clock_flag || !checks_done)
        && (pwdata_in[AXES-1:0] != '0);

    always_ff @(posedge clock_in) begin
        if (restart) begin
            motor_enable_out <= '0;
        end else if (missing_clock_flag) begin
            motor_enable_out <= '0;
        end else if (motor_req && checks_done) begin
            motor_enable_out <= pwdata_in[AXES-1:0];
        end
    end

    // event status: sticky, write one to clear, set wins over clear
    logic [`INT_WIDTH-1:0] int_status;
    logic [`INT_WIDTH-1:0] int_mask;
    logic [`INT_WIDTH-1:0] int_event;
    logic abort_flag_d;
    logic clk_flag_d;
    logic buf_flag_d;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            abort_flag_d <= 1'b0;
            clk_flag_d <= 1'b0;
            buf_flag_d <= 1'b0;
        end else begin
            abort_flag_d <= global_abort_flag;
            clk_flag_d <= missing_clock_flag;
            buf_flag_d <= buffer_overflow_flag;
        end
    end

    always_comb begin
        int_event = '0;
        int_event[`BUF_OVF_BIT] = buffer_overflow_flag & ~buf_flag_d;
        int_event[`ABORT_BIT] = global_abort_flag & ~abort_flag_d;
        int_event[`NO_CLK_BIT] = missing_clock_flag & ~clk_flag_d;
        int_event[`MOTOR_REFUSED_BIT] = motor_refused;
    end

    logic [`INT_WIDTH-1:0] int_clear;
    assign int_clear = (wr_en && paddr_in == `INT_STATUS_OFFSET
        && pstrb_in[0]) ? pwdata_in[`INT_WIDTH-1:0] : '0;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~int_clear) | int_event;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            int_mask <= `INT_MASK_RESET;
        end else if (wr_en && paddr_in == `INT_MASK_OFFSET
                && pstrb_in[0]) begin
            int_mask <= pwdata_in[`INT_WIDTH-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(int_status & int_mask);
        end
    end

    // read mux; flag register has no write path at all
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (paddr_in)
            `FLAG_STATUS_OFFSET: begin
                next_prdata[`BUF_OVF_BIT] = buffer_overflow_flag;
                next_prdata[`ABORT_BIT] = global_abort_flag;
                next_prdata[`NO_CLK_BIT] = missing_clock_flag;
            end
            `INT_STATUS_OFFSET: next_prdata[`INT_WIDTH-1:0] = int_status;
            `INT_MASK_OFFSET: next_prdata[`INT_WIDTH-1:0] = int_mask;
            `BUF_SIZE_OFFSET: next_prdata = {buffer_size_out, buf_size_cfg};
            `MOTOR_CMD_OFFSET: next_prdata[AXES-1:0] = motor_enable_out;
            `CHECK_CTRL_OFFSET: next_prdata[0] = checks_done;
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // data registered at setup so it is stable in the access phase
    // so a read shows state from one cycle before its access edge
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            prdata_out <= next_prdata;
        end
    end

endmodule

// ===== dv/sys_flag_properties.sv
`timescale 1ns/1ps
`include "sys_flag_map.svh"
module sys_flag_properties #(
    parameter int CLK_WINDOW = 16,
    parameter int AXES = 8
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic reset_cmd_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic [AXES-1:0] motor_enable_out,
    input wire logic [15:0] buffer_size_out
);
    logic [15:0] since_rst;
    logic [2:0] quiet;
    logic [2:0] seen;
    logic rd_flag;
    logic setup_rd;
    logic motor_wr;
    assign setup_rd = psel_in && !penable_in && !pwrite_in;
    assign motor_wr = psel_in && penable_in && pwrite_in &&
        paddr_in == `MOTOR_CMD_OFFSET;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // saturating counts, so they stay cheap over long runs
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            since_rst <= '0;
        end else if (since_rst < 16'(CLK_WINDOW)) begin
            since_rst <= since_rst + 16'h0001;
        end
    end
    always_ff @(posedge clock_in) begin
        if (rst_in || reset_cmd_in) begin
            quiet <= '0;
        end else if (quiet != 3'h4) begin
            quiet <= quiet + 3'h1;
        end
    end
    always_ff @(posedge clock_in) begin
        rd_flag <= setup_rd && paddr_in == `FLAG_STATUS_OFFSET;
        if (rst_in || reset_cmd_in) begin
            seen <= '0;
        end else if (rd_flag) begin
            seen <= prdata_out[2:0];
        end
    end
    a_size_in_range: assert property (
        buffer_size_out <= `RAM_CAPACITY)
        else $error("active buffer size above capacity");
    a_size_held: assert property (quiet == 3'h4 |->
        $stable(buffer_size_out))
        else $error("buffer size changed outside a check");
    a_motor_wait: assert property (since_rst < 16'(CLK_WINDOW) |->
        motor_enable_out == '0) else $error("motor enabled before checks");
    a_motor_by_write: assert property ($changed(motor_enable_out) &&
        motor_enable_out != '0 |-> $past(motor_wr))
        else $error("motor enabled without a write");
    a_read_data_hold: assert property (!$past(setup_rd) |->
        $stable(prdata_out)) else $error("read data moved without a read");
    a_flag_upper_zero: assert property (rd_flag |->
        prdata_out[31:3] == '0) else $error("flag word has extra bits");
    a_clock_blocks_motor: assert property (rd_flag &&
        prdata_out[`NO_CLK_BIT] |-> motor_enable_out == '0)
        else $error("motor on with clock missing");
    a_flag_sticky_bits: assert property (rd_flag && !reset_cmd_in |->
        (seen & ~prdata_out[2:0]) == 3'h0) else $error("flag cleared");
    cover property (motor_wr);
    cover property (rd_flag && prdata_out[`NO_CLK_BIT]);
    cover property (rd_flag && prdata_out[`ABORT_BIT]);
endmodule

// ===== dv/system_error_flag_bank_tb.sv
`timescale 1ns/1ps
`include "sys_flag_map.svh"
module system_error_flag_bank_tb;
    logic clock_in, rst_in, reset_cmd_in, abort_in, phase_clk_in;
    logic servo_clk_in, psel_in, penable_in, pwrite_in, clk_run, err;
    logic pready_out, pslverr_out, irq_out;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [3:0] pstrb_in;
    logic [7:0] motor_enable_out;
    logic [15:0] buffer_size_out;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int n;

    system_error_flag_bank #(.CLK_WINDOW(16), .AXES(8)) uut (
        .clock_in, .rst_in, .reset_cmd_in, .abort_in, .phase_clk_in,
        .servo_clk_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
        .motor_enable_out, .buffer_size_out, .irq_out
    );

    initial begin
        clock_in = 0;
        forever #5 clock_in = ~clock_in;
    end

    // pin clocks held two cycles so sync stages 2 and 3 can agree
    // phase clock can be stopped, servo clock always runs
    always @(posedge clock_in) begin
        if (cycles % 2 == 0) begin
            if (clk_run) begin
                phase_clk_in <= ~phase_clk_in;
            end
            servo_clk_in <= ~servo_clk_in;
        end
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end

    task automatic results();
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1;
        penable_in <= 0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask

    task automatic wait_done();
        n = 0;
        do begin
            apb(0, `CHECK_CTRL_OFFSET, '0);
            n++;
        end while (rd[0] !== 1'b1 && n < 50);
        check(32'(rd[0]), 32'h0000_0001);
    endtask

    task automatic restart();
        @(posedge clock_in);
        reset_cmd_in <= 1;
        @(posedge clock_in);
        reset_cmd_in <= 0;
        wait_done();
    endtask

    initial begin
        {reset_cmd_in, abort_in, phase_clk_in, servo_clk_in} = '0;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        pstrb_in = 4'hf;
        clk_run = 1;
        rst_in = 1;
        repeat (2) @(posedge clock_in);
        rst_in <= 0;
        wait_done();
        apb(1, `MOTOR_CMD_OFFSET, 32'h0000_00a5);
        @(posedge clock_in);
        check(32'(motor_enable_out), 32'h0000_00a5);
        apb(1, `BUF_SIZE_OFFSET, 32'h0000_2000);
        restart();
        apb(0, `FLAG_STATUS_OFFSET, '0);
        check(rd, 32'h0000_0001);
        check(32'(buffer_size_out), 32'h0000_0100);
        // a legal size and a flag write must both be ignored until restart
        apb(1, `BUF_SIZE_OFFSET, 32'h0000_0200);
        apb(1, `FLAG_STATUS_OFFSET, '0);
        apb(0, `FLAG_STATUS_OFFSET, '0);
        check(rd, 32'h0000_0001);
        check(32'(buffer_size_out), 32'h0000_0100);
        restart();
        apb(0, `FLAG_STATUS_OFFSET, '0);
        check(rd, 32'h0000_0000);
        check(32'(buffer_size_out), 32'h0000_0200);
        abort_in <= 1;
        repeat (8) @(posedge clock_in);
        abort_in <= 0;
        repeat (8) @(posedge clock_in);
        apb(0, `FLAG_STATUS_OFFSET, '0);
        check(rd, 32'h0000_0002);
        check(32'(irq_out), 32'h0000_0000);
        apb(1, `INT_MASK_OFFSET, 32'h0000_0002);
        repeat (2) @(posedge clock_in);
        check(32'(irq_out), 32'h0000_0001);
        apb(1, `INT_STATUS_OFFSET, 32'h0000_0002);
        repeat (2) @(posedge clock_in);
        check(32'(irq_out), 32'h0000_0000);
        clk_run <= 0;
        restart();
        apb(0, `FLAG_STATUS_OFFSET, '0);
        check(rd, 32'h0000_0004);
        check(32'(motor_enable_out), 32'h0000_0000);
        apb(1, `MOTOR_CMD_OFFSET, 32'h0000_00ff);
        @(posedge clock_in);
        check(32'(motor_enable_out), 32'h0000_0000);
        apb(0, `INT_STATUS_OFFSET, '0);
        check(32'(rd[`MOTOR_REFUSED_BIT]), 32'h0000_0001);
        apb(1, 12'h020, '0);
        check(32'(err), 32'h0000_0001);
        results();
    end
endmodule

bind system_error_flag_bank sys_flag_properties #(
    .CLK_WINDOW(CLK_WINDOW),
    .AXES(AXES)
) chk (
    .clock_in, .rst_in, .reset_cmd_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .prdata_out, .motor_enable_out, .buffer_size_out
);
